// ==== logic/xor_ze_alu.v ====
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "xor_ze_map.vh"
// Executes XOR (four forms) and zero-extend; one instruction per issue.
// Data memory is byte addressed, 16 bits wide, read combinationally.
module xor_ze_alu (
	// Clock and reset
	input  wire        clk,
	input  wire        reset,
	// Instruction issue
	input  wire        issue,
	input  wire [23:0] opcode,
	// Data memory read port
	output wire [15:0] mem_raddr_s,
	output wire [15:0] mem_raddr_d,
	input  wire [15:0] mem_rdata_s,
	input  wire [15:0] mem_rdata_d,
	// Data memory write port (registered)
	output reg         mem_we,
	output reg  [15:0] mem_waddr,
	output reg  [15:0] mem_wdata,
	output reg  [1:0]  mem_wbe,
	// Status and observation
	output reg  [15:0] status_q,
	output reg         done_q,
	output reg         illegal_q,
	// Register file observation port
	input  wire [3:0]  dbg_sel,
	output reg  [15:0] dbg_data_q
);
	reg  [15:0] default_working_reg_q [0:15];
	reg  [15:0] default_working_reg_d [0:15];
	integer     i;
	integer     j;

	// Opcode recognition, used by several processes
	// (RQ15) Zero-extend top pattern
	function [2:0] classify;
		input [23:0] op;
		begin
			if (op[23:14] == `OP_ZE_TOP)
				classify = 3'h4;
			else if (op[23:16] == `OP_FILE_TOP && op[`BIT_FILE_FLAG])
				classify = 3'h1;
			else if (op[23:16] == `OP_LIT_TOP && op[`BIT_FILE_FLAG])
				classify = 3'h2;
			else if (op[23:20] == `OP_REG_TOP && op[19])
				classify = 3'h3;
			else
				classify = 3'h0;
		end
	endfunction

	// Byte-lane merge keeps the untouched byte
	function [15:0] merge;
		input [15:0] old;
		input [15:0] res;
		input        byte_op;
		begin
			merge = byte_op ? {old[15:8], res[7:0]} : res;
		end
	endfunction

	wire [2:0]  kind = classify(opcode);
	wire        is_file = (kind == 3'h1);
	wire        is_lit = (kind == 3'h2);
	wire        is_reg = (kind == 3'h3);
	wire        is_ze = (kind == 3'h4);
	// (RQ3) Width select
	wire        byte_op = is_file ? opcode[`BIT_WIDTH_F] :
	                      is_ze ? 1'b1 : opcode[`BIT_WIDTH_R];
	// (RQ10) Register form fields
	wire [3:0]  base_n = opcode[18:15];
	wire [2:0]  dmode = opcode[13:11];
	wire [3:0]  dest_n = opcode[10:7];
	wire [2:0]  smode = opcode[6:4];
	wire [3:0]  src_n = opcode[3:0];
	// (RQ17) Short literal selector
	wire        short_lit = opcode[6:5] == `SHORT_LIT_SEL;
	wire [4:0]  five_bit_literal = opcode[4:0];
	// (RQ7) Literal and single register
	wire [9:0]  ten_bit_literal = opcode[13:4];
	wire [3:0]  single_work_reg = opcode[3:0];
	// (RQ2) File address, 13 bits
	wire [12:0] file_addr = opcode[12:0];

	wire [15:0] s_addr;
	wire [15:0] s_new;
	wire        s_upd;
	wire        s_ind;
	wire [15:0] d_addr;
	wire [15:0] d_new;
	wire        d_upd;
	wire        d_ind;
	wire        src_mode_used = (is_reg && !short_lit) || is_ze;
	// (RQ14) Zero-extend source is always a byte operand
	addr_step u_src (
		.mode      (src_mode_used ? smode : `MODE_DIRECT),
		.ptr       (default_working_reg_q[src_n]),
		.byte_op   (byte_op),
		.eff_addr  (s_addr),
		.new_ptr   (s_new),
		.ptr_write (s_upd),
		.indirect  (s_ind)
	);
	// (RQ9) Destination any mode for register forms
	// (RQ13) Zero-extend destination forced direct
	addr_step u_dst (
		.mode      (is_reg ? dmode : `MODE_DIRECT),
		.ptr       (default_working_reg_q[dest_n]),
		.byte_op   (byte_op),
		.eff_addr  (d_addr),
		.new_ptr   (d_new),
		.ptr_write (d_upd),
		.indirect  (d_ind)
	);

	assign mem_raddr_s = is_file ? {3'h0, file_addr} : s_addr;
	assign mem_raddr_d = d_addr;

	// Odd byte address picks the high lane of the memory word
	wire [7:0]  s_mem_byte = s_addr[0] ? mem_rdata_s[15:8] : mem_rdata_s[7:0];
	wire [7:0]  f_mem_byte = file_addr[0] ? mem_rdata_s[15:8]
	                                      : mem_rdata_s[7:0];
	wire [15:0] src_val = s_ind ? (byte_op ? {8'h00, s_mem_byte} : mem_rdata_s)
	                            : default_working_reg_q[src_n];
	wire [15:0] file_val = byte_op ? {8'h00, f_mem_byte} : mem_rdata_s;

	reg  [15:0] result;
	reg  [15:0] a_op;
	reg  [15:0] b_op;
	reg  [15:0] status_d;
	reg         to_mem;
	reg  [15:0] wr_addr;
	reg         to_default_working_reg;
	reg  [3:0]  wr_reg;
	reg  [15:0] wr_old;
	reg         flag_n;
	reg         flag_z;

	// Operand selection and result
	always @* begin
		a_op = 16'h0000;
		b_op = 16'h0000;
		to_mem = 1'b0;
		to_default_working_reg = 1'b0;
		wr_addr = 16'h0000;
		wr_reg = 4'h0;
		wr_old = 16'h0000;
		case (kind)
		3'h1: begin
			// (RQ1) File XOR default register
			// (RQ4) Default register is register zero
			a_op = file_val;
			b_op = default_working_reg_q[`DEFAULT_WORKING_REG_DEFAULT];
			if (opcode[`BIT_DEST]) begin
				to_mem = 1'b1;
				wr_addr = {3'h0, file_addr};
			end else begin
				to_default_working_reg = 1'b1;
				wr_reg = `DEFAULT_WORKING_REG_DEFAULT;
				wr_old = default_working_reg_q[`DEFAULT_WORKING_REG_DEFAULT];
			end
		end
		3'h2: begin
			// (RQ5) Literal into same register
			a_op = {6'h00, ten_bit_literal};
			b_op = default_working_reg_q[single_work_reg];
			to_default_working_reg = 1'b1;
			wr_reg = single_work_reg;
			wr_old = default_working_reg_q[single_work_reg];
		end
		3'h3: begin
			// (RQ8) Base XOR source or short literal
			a_op = default_working_reg_q[base_n];
			b_op = short_lit ? {11'h000, five_bit_literal} : src_val;
			to_mem = d_ind;
			to_default_working_reg = !d_ind;
			wr_addr = d_addr;
			wr_reg = dest_n;
			wr_old = default_working_reg_q[dest_n];
		end
		3'h4: begin
			// (RQ11) Zero-extend low byte
			b_op = {8'h00, src_val[7:0]};
			to_default_working_reg = 1'b1;
			wr_reg = dest_n;
		end
		default: begin
		end
		endcase
		result = a_op ^ b_op;
		if (is_ze)
			result = {8'h00, result[7:0]};
		// (RQ18) Byte mode keeps upper byte
		result = is_ze ? result : merge(wr_old, result, byte_op);
	end

	// Flags from the operation width
	always @* begin
		status_d = status_q;
		// (RQ16) Negative and zero at width
		flag_n = byte_op ? result[7] : result[15];
		flag_z = byte_op ? (result[7:0] == 8'h00) : (result == 16'h0000);
		if (is_ze) begin
			// (RQ12) N clear, C set, Z word
			status_d[`SR_N] = 1'b0;
			status_d[`SR_C] = 1'b1;
			status_d[`SR_Z] = (result == 16'h0000);
		end else if (kind != 3'h0) begin
			status_d[`SR_N] = flag_n;
			status_d[`SR_Z] = flag_z;
		end
	end

	// Register file next state; pointer updates first, result wins
	always @* begin
		for (i = 0; i < 16; i = i + 1)
			default_working_reg_d[i] = default_working_reg_q[i];
		if (issue && kind != 3'h0) begin
			if (s_upd)
				default_working_reg_d[src_n] = s_new;
			if (d_upd)
				default_working_reg_d[dest_n] = d_new;
			if (to_default_working_reg)
				default_working_reg_d[wr_reg] = result;
		end
	end

	// Sequential state; unrecognised opcodes only raise illegal
	always @(posedge clk) begin
		if (reset) begin
			for (j = 0; j < 16; j = j + 1)
				default_working_reg_q[j] <= 16'h0000;
			status_q <= 16'h0000;
			done_q <= 1'b0;
			illegal_q <= 1'b0;
			mem_we <= 1'b0;
			mem_waddr <= 16'h0000;
			mem_wdata <= 16'h0000;
			mem_wbe <= 2'h0;
			dbg_data_q <= 16'h0000;
		end else begin
			for (j = 0; j < 16; j = j + 1)
				default_working_reg_q[j] <= default_working_reg_d[j];
			done_q <= issue && kind != 3'h0;
			illegal_q <= issue && kind == 3'h0;
			mem_we <= issue && to_mem;
			mem_waddr <= wr_addr;
			// Byte writes copy the byte to both lanes; the enable selects the lane of the address
			mem_wdata <= byte_op ? {result[7:0], result[7:0]} : result;
			mem_wbe <= byte_op ? (wr_addr[0] ? 2'h2 : 2'h1) : 2'h3;
			if (issue && kind != 3'h0)
				status_q <= status_d;
			dbg_data_q <= default_working_reg_d[dbg_sel];
		end
	end
endmodule
`default_nettype wire

// ==== logic/xor_ze_map.vh ====
// Contract
// (RQ1) File form: file register XOR default register; destination bit picks target.
// (RQ2) File form address is the 13 low opcode bits, 0 to 8191.
// (RQ3) Width bit 0 means word, 1 means byte, in every XOR form.
// (RQ4) Default working register is working register zero.
// (RQ5) Literal form XORs 10-bit literal into named register, direct only.
// (RQ6) Software keeps literal within 255 for byte, 1023 for word.
// (RQ7) Literal taken from k field; register number from lowest nibble.
// (RQ8) Register form: source XOR base register stored to destination operand.
// (RQ9) Base register direct only; source and destination any indirect mode.
// (RQ10) Register form decodes w, q, d, p and s fields.
// (RQ11) Zero-extend copies source low byte, clears destination bits 15 to 8.
// (RQ12) Zero-extend clears negative, sets carry, zero from 16-bit result.
// (RQ13) Zero-extend source direct or indirect, destination direct only.
// (RQ14) Zero-extend source fetched as byte; pointer steps by one.
// (RQ15) Zero-extend recognised by top pattern 1111 1011 10.
// (RQ16) XOR sets negative from result top bit, zero when result zero.
// (RQ17) Short-literal form XORs base with 5-bit literal; bits 6:5 are 11.
// (RQ18) Byte mode keeps upper destination byte; negative from bit 7.
`ifndef XOR_ZE_MAP_VH
`define XOR_ZE_MAP_VH
`define OP_FILE_TOP   8'hB6
`define OP_LIT_TOP    8'hB2
`define OP_REG_TOP    4'h6
`define OP_ZE_TOP     10'h3EE
`define BIT_FILE_FLAG 15
`define BIT_WIDTH_F   14
`define BIT_DEST      13
`define BIT_WIDTH_R   14
`define SHORT_LIT_SEL 2'h3
`define MODE_DIRECT   3'h0
`define MODE_IND      3'h1
`define MODE_POSTDEC  3'h2
`define MODE_POSTINC  3'h3
`define MODE_PREDEC   3'h4
`define MODE_PREINC   3'h5
`define SR_C          0
`define SR_Z          1
`define SR_N          3
`define DEFAULT_WORKING_REG_DEFAULT  4'h0
`endif

// ==== logic/addr_step.v ====
`timescale 1ns/1ps
`default_nettype none
`include "xor_ze_map.vh"
// Effective address and pointer update for one operand
module addr_step (
	// Mode and pointer
	input  wire [2:0]  mode,
	input  wire [15:0] ptr,
	input  wire        byte_op,
	// Results
	output reg  [15:0] eff_addr,
	output reg  [15:0] new_ptr,
	output reg         ptr_write,
	output reg         indirect
);
	reg [15:0] step;
	// Byte accesses move the pointer by one, words by two
	always @* begin
		step = byte_op ? 16'h0001 : 16'h0002;
		eff_addr = ptr;
		new_ptr = ptr;
		ptr_write = 1'b0;
		indirect = 1'b1;
		case (mode)
		`MODE_DIRECT: begin
			indirect = 1'b0;
		end
		`MODE_POSTINC: begin
			new_ptr = ptr + step;
			ptr_write = 1'b1;
		end
		`MODE_POSTDEC: begin
			new_ptr = ptr - step;
			ptr_write = 1'b1;
		end
		`MODE_PREINC: begin
			new_ptr = ptr + step;
			eff_addr = ptr + step;
			ptr_write = 1'b1;
		end
		`MODE_PREDEC: begin
			new_ptr = ptr - step;
			eff_addr = ptr - step;
			ptr_write = 1'b1;
		end
		default: begin
		end
		endcase
	end
endmodule
`default_nettype wire

// ==== bench/xor_ze_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "xor_ze_map.vh"
// Port-level checks of the XOR and zero-extend unit
module xor_ze_chk (
	// Clock, reset and issue
	input wire        clk,
	input wire        reset,
	input wire        issue,
	input wire [23:0] opcode,
	// Results
	input wire [15:0] mem_raddr_s,
	input wire        mem_we,
	input wire [15:0] mem_waddr,
	input wire [1:0]  mem_wbe,
	input wire [15:0] status_q,
	input wire        done_q,
	input wire        illegal_q
);
	// Own form decode, kept apart from the design's
	wire f_op = opcode[23:15] == 9'h16D;
	wire l_op = opcode[23:15] == 9'h165;
	wire r_op = opcode[23:19] == 5'h0D;
	wire z_op = opcode[23:14] == 10'h3EE;
	wire x_op = f_op | l_op | r_op;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_legal; issue && (x_op | z_op) |=> done_q && !illegal_q;
	endproperty
	a_legal: assert property (p_legal) else $error("done missing");
	property p_refuse; issue && !(x_op | z_op) |=> illegal_q && !mem_we;
	endproperty
	a_refuse: assert property (p_refuse) else $error("not refused");
	property p_faddr; issue && f_op |-> mem_raddr_s == {3'h0, opcode[12:0]};
	endproperty
	a_faddr: assert property (p_faddr) else $error("file address");
	property p_fdst; issue && f_op |=> mem_we == $past(opcode[13]);
	endproperty
	a_fdst: assert property (p_fdst) else $error("file target");
	property p_fbe; issue && f_op && opcode[13] |=> mem_wbe == ($past(opcode[14])
		? {$past(opcode[0]), !$past(opcode[0])} : 2'h3); endproperty
	a_fbe: assert property (p_fbe) else $error("byte lanes");
	property p_nomem; issue && (l_op | z_op) |=> !mem_we; endproperty
	a_nomem: assert property (p_nomem) else $error("memory write");
	property p_ze; issue && z_op |=> status_q[`SR_C] && !status_q[`SR_N];
	endproperty
	a_ze: assert property (p_ze) else $error("extend flags");
	property p_keepc; issue && x_op |=> $stable(status_q[`SR_C]); endproperty
	a_keepc: assert property (p_keepc) else $error("carry moved");
	property p_rdst; issue && r_op |=> mem_we == ($past(opcode[13:11]) != 0);
	endproperty
	a_rdst: assert property (p_rdst) else $error("dest mode");
endmodule
bind xor_ze_alu xor_ze_chk chk (.clk, .reset, .issue, .opcode, .mem_raddr_s,
	.mem_we, .mem_waddr, .mem_wbe, .status_q, .done_q, .illegal_q);
`default_nettype wire

// ==== bench/test_xor_ze_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "xor_ze_map.vh"
module test_xor_ze_alu;
	// Drive, observe and reference state
	logic        clk = 0;
	logic        reset = 1;
	logic        issue = 0;
	logic [23:0] opcode = 0;
	logic [3:0]  dbg_sel = 0;
	wire  [15:0] raddr_s, raddr_d, waddr, wdata, status, dbg;
	wire  [1:0]  wbe;
	wire         we, done, ill;
	logic [15:0] dmem [0:255];
	logic [15:0] w [0:15];
	logic [15:0] sr = 0;
	logic [15:0] e_addr, e_data;
	logic [1:0]  e_be;
	logic        e_we, e_ill;
	logic [23:0] op;
	logic [23:0] dir [0:8] = '{24'hB6FFFF, 24'hB68A04, 24'hB2BFF4, 24'hB2CFF0,
		24'hFB8203, 24'hFB8634, 24'h68DCB5, 24'h6A02F6, 24'h000000};
	integer      num_errors = 0;
	integer      n_checks = 0;
	integer      seed = 32'hdd0a4011;
	integer      i, k;
	wire  [15:0] rd_s = dmem[raddr_s[8:1]];
	wire  [15:0] rd_d = ~rd_s;
	always #20 clk = ~clk;
	xor_ze_alu uut (.clk(clk), .reset(reset), .issue(issue), .opcode(opcode),
		.mem_raddr_s(raddr_s), .mem_raddr_d(raddr_d), .mem_rdata_s(rd_s),
		.mem_rdata_d(rd_d), .mem_we(we), .mem_waddr(waddr), .mem_wdata(wdata),
		.mem_wbe(wbe), .status_q(status), .done_q(done), .illegal_q(ill),
		.dbg_sel(dbg_sel), .dbg_data_q(dbg));
	// Memory honours the byte enables
	always @(posedge clk) begin
		if (we && wbe[0]) dmem[waddr[8:1]][7:0] <= wdata[7:0];
		if (we && wbe[1]) dmem[waddr[8:1]][15:8] <= wdata[15:8];
	end
	task chk(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic [15:0] rdb(input [15:0] a, input b);
		rdb = dmem[a[8:1]];
		if (b) rdb = a[0] ? {8'h0, rdb[15:8]} : {8'h0, rdb[7:0]};
	endfunction
	task automatic opnd(input [2:0] m, input [3:0] r, input b,
		output [15:0] a);
		logic [15:0] s;
		s = b ? 16'h1 : 16'h2;
		if (m == 3'h4) w[r] = w[r] - s;
		if (m == 3'h5) w[r] = w[r] + s;
		a = w[r];
		if (m == 3'h2) w[r] = w[r] - s;
		if (m == 3'h3) w[r] = w[r] + s;
	endtask
	// Reference for one instruction; base read before any pointer moves
	task automatic model(input [23:0] o);
		logic [15:0] a, ad, x, y, r, sv;
		logic [3:0]  d;
		logic        b, z, dm;
		b = o[14];
		z = o[23:14] == 10'h3EE;
		{dm, e_we, e_ill, d, ad} = {3'h0, o[10:7], 16'h0};
		y = w[o[18:15]];
		sv = w[o[3:0]];
		if (o[23:16] == `OP_FILE_TOP && o[15]) begin
			{ad, dm, d} = {3'h0, o[12:0], o[13], 4'h0};
			x = rdb(ad, b);
			y = w[0];
		end else if (o[23:16] == `OP_LIT_TOP && o[15]) begin
			d = o[3:0];
			x = {6'h0, o[13:4]};
			y = w[d];
		end else if (z || (o[23:20] == `OP_REG_TOP && o[19])) begin
			opnd(o[6:4], o[3:0], b | z, a);
			x = o[6:4] == 0 ? sv : rdb(a, b | z);
			if (o[6:5] == 2'h3 && !z) x = {11'h0, o[4:0]};
			if (!z) opnd(o[13:11], d, b, ad);
			dm = !z && o[13:11] != 0;
		end else
			e_ill = 1;
		if (!e_ill) begin
			r = z ? {8'h0, x[7:0]} : x ^ y;
			sr[`SR_N] = b ? r[7] : r[15];
			sr[`SR_Z] = b ? r[7:0] == 0 : r == 0;
			if (z) sr[`SR_C] = 1;
			{e_we, e_addr, e_be} = {dm, ad, b ? {ad[0], !ad[0]} : 2'h3};
			e_data = b ? {2{r[7:0]}} : r;
			if (!dm) w[d] = b ? {w[d][15:8], r[7:0]} : r;
		end
	endtask
	task automatic run(input [23:0] o);
		@(posedge clk);
		issue <= 1;
		opcode <= o;
		#1 model(o);
		if (e_we && o[23:20] == `OP_REG_TOP) chk(raddr_d, e_addr);
		@(posedge clk);
		issue <= 0;
		#1 chk({done, ill, we}, {!e_ill, e_ill, e_we});
		if (e_we) chk({waddr, wdata, wbe}, {e_addr, e_data, e_be});
		chk(status, sr);
	endtask
	task automatic regs;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			dbg_sel <= k[3:0];
			@(posedge clk);
			#1 chk(dbg, w[k]);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		conclude;
	end
	initial begin
		for (k = 0; k < 256; k++) dmem[k] = 16'($random(seed));
		for (k = 0; k < 16; k++) w[k] = 0;
		repeat (12) @(posedge clk);
		reset <= 0;
		#1 chk({status, done, ill, we}, 0);
		regs;
		$display("reset test done");
		for (i = 0; i < 9; i++) run(dir[i]);
		regs;
		$display("directed test done");
		// Random mix; byte literals kept within 255
		for (i = 0; i < 600; i++) begin
			op = 24'($random(seed));
			case (i % 4)
				0: op[23:15] = 9'h16D;
				1: {op[23:15], op[13:12]} = {9'h165, op[14] ? 2'h0 : op[13:12]};
				2: op[23:19] = 5'h0D;
				default: op[23:11] = 13'h1F70;
			endcase
			if (op[10:7] == op[3:0]) op[10:7] = op[3:0] + 4'h1;
			if (i % 50 == 49) op[23:16] = 8'h00;
			run(op);
		end
		regs;
		$display("random test done");
		conclude;
	end
endmodule
`default_nettype wire
